// ==== rtl/pllodb_top.sv ====
// Summary of operation
// - Three banks of four clock outputs and one return output, each bank set by its own select.
// - Each bank divides the oscillator clock directly by its selected ratio.
// - The halving select puts one divide-by-two stage ahead of all banks, ratios kept.
// - Only an outside feedback path is used; the return output is routed back externally.
// - The top return select bit halves the return clock, doubling outputs against reference.
// - The return divider offers seven distinct ratios, independent of the bank settings.
// - The invert select inverts outputs two and three of the third bank by half a period.
// - Lock is reported 10 ms and one cycle after a divide setting last changed.
// - Each output is frozen or released through a serial input port.
// - A frozen output is held low while its divider keeps counting, staying in phase.
// - A freeze or release takes effect only while the output is low.
// - Reset clears every freeze so that all outputs run.
`timescale 1ns/10ps
module pllodb_top
   import pllodb_pkg::*;
#(
   parameter int LOCK_CNT = LOCK_CYCLES                  // Settle time in cycles
) (
   input  wire logic        clk,                         // Oscillator clock
   input  wire logic        sys_rst,                     // Synchronous reset, high
   input  wire logic        psel,                        // APB select
   input  wire logic        penable,                     // APB enable
   input  wire logic        pwrite,                      // APB direction
   input  wire logic [7:0]  paddr,                       // APB byte address
   input  wire logic [31:0] pwdata,                      // APB write data
   output logic      [31:0] prdata,                      // APB read data
   output logic             pready,                      // APB ready
   output logic             pslverr,                     // APB error
   input  wire logic        frz_clk,                     // Serial freeze clock pin
   input  wire logic        frz_data,                    // Serial freeze data pin
   output logic      [3:0]  first_bank_outputs,          // First bank clocks
   output logic      [3:0]  second_bank_outputs,         // Second bank clocks
   output logic      [3:0]  third_bank_outputs,          // Third bank clocks
   output logic             loop_return_output,          // Return clock to loop input
   output logic             lock_ok                      // Settle time elapsed
);

   localparam int LOCK_W = $clog2(LOCK_CNT + 1);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [CTRL_W-1:0]    ctrl_ff;
   logic                 restart_ff;
   logic                 prescale_ff;
   logic                 tick;
   logic [LOCK_W-1:0]    lock_cnt_ff;
   logic                 lock_ff;
   logic [31:0]          prdata_ff;
   logic                 pready_ff;
   logic                 pslverr_ff;
   logic [31:0]          nxt_rdata;
   logic                 nxt_mapped;
   logic                 wr_ctrl;
   logic [2:0]           clk_sync_ff;
   logic [2:0]           dat_sync_ff;
   logic                 clk_lvl_ff;
   logic                 frz_edge;
   pllodb_frz_state_t    frz_state_ff;
   logic [FRZ_CNT_W-1:0] frz_bits_ff;
   logic [FRZ_BITS-1:0]  frz_shift_ff;
   logic [FRZ_BITS-1:0]  frz_req_ff;
   logic [FRZ_BITS-1:0]  frozen;
   logic [HALF_W-1:0]    half_a;
   logic [HALF_W-1:0]    half_b;
   logic [HALF_W-1:0]    half_c;
   logic [HALF_W-1:0]    half_fb;
   logic [3:0]           inv_c;
   logic [3:0]           q_a;
   logic [3:0]           q_b;
   logic [3:0]           q_c;
   logic                 q_fb;

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------

   // Read mux and address decode
   always_comb begin
      nxt_rdata  = 32'h0000_0000;
      nxt_mapped = 1'b1;
      unique case (paddr)
         REG_CTRL_OFS: nxt_rdata[CTRL_W-1:0]   = ctrl_ff;
         REG_FRZ_OFS:  nxt_rdata[FRZ_BITS-1:0] = frozen;
         REG_STAT_OFS: begin
            nxt_rdata[STAT_LOCK_POS] = lock_ff;
            nxt_rdata[STAT_BUSY_POS] = (frz_state_ff == PLLODB_FRZ_SHIFT);
         end
         REG_OUTS_OFS: nxt_rdata[FRZ_BITS-1:0] = {q_fb, q_c, q_b, q_a};
         default:      nxt_mapped = 1'b0;
      endcase
   end

   // Ready in first access cycle, data and error captured at setup
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= psel & ~penable;
         pslverr_ff <= psel & ~penable & ~nxt_mapped;
         if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_rdata;
         end
      end
   end

   assign wr_ctrl = psel & penable & pready_ff & pwrite & (paddr == REG_CTRL_OFS);

   // Control register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_ff <= pwdata[CTRL_W-1:0];
      end
   end

   // Realign all dividers when any divide setting changes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         restart_ff <= 1'b0;
      end else begin
         restart_ff <= wr_ctrl &&
                       (pwdata[CTRL_HALVE_POS:0] != ctrl_ff[CTRL_HALVE_POS:0]);
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and settle timer
   // ----------------------------------------------------------------

   // Optional divide-by-two ahead of every bank
   always_ff @(posedge clk) begin
      if (sys_rst || restart_ff) begin
         prescale_ff <= 1'b0;
      end else begin
         prescale_ff <= ~prescale_ff;
      end
   end

   assign tick = ~ctrl_ff[CTRL_HALVE_POS] | prescale_ff;

   // Settle timer restarts on every divide change
   always_ff @(posedge clk) begin
      if (sys_rst || restart_ff) begin
         lock_cnt_ff <= '0;
         lock_ff     <= 1'b0;
      end else if (lock_cnt_ff == LOCK_W'(LOCK_CNT - 1)) begin
         lock_ff     <= 1'b1;
      end else begin
         lock_cnt_ff <= lock_cnt_ff + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Serial freeze port
   // ----------------------------------------------------------------

   // Pin synchronisers, three stages
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clk_sync_ff <= 3'h0;
         dat_sync_ff <= 3'h0;
      end else begin
         clk_sync_ff <= {clk_sync_ff[1:0], frz_clk};
         dat_sync_ff <= {dat_sync_ff[1:0], frz_data};
      end
   end

   // Accepted clock level, changes once stages two and three agree
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clk_lvl_ff <= 1'b0;
      end else if (clk_sync_ff[1] == clk_sync_ff[2]) begin
         clk_lvl_ff <= clk_sync_ff[2];
      end
   end

   assign frz_edge = (clk_sync_ff[1] == clk_sync_ff[2]) & clk_sync_ff[2] & ~clk_lvl_ff;

   // Start bit of one, then thirteen freeze bits, lowest first
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frz_state_ff <= PLLODB_FRZ_IDLE;
         frz_bits_ff  <= '0;
         frz_shift_ff <= '0;
      end else if (frz_edge) begin
         unique case (frz_state_ff)
            PLLODB_FRZ_IDLE: begin
               if (dat_sync_ff[2]) begin
                  frz_state_ff <= PLLODB_FRZ_SHIFT;
                  frz_bits_ff  <= '0;
               end
            end
            PLLODB_FRZ_SHIFT: begin
               frz_shift_ff <= {dat_sync_ff[2], frz_shift_ff[FRZ_BITS-1:1]};
               frz_bits_ff  <= frz_bits_ff + 4'h1;
               if (frz_bits_ff == FRZ_CNT_W'(FRZ_BITS - 1)) begin
                  frz_state_ff <= PLLODB_FRZ_IDLE;
               end
            end
         endcase
      end
   end

   // Freeze request, updated when a frame completes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frz_req_ff <= '0;
      end else if (frz_edge && frz_state_ff == PLLODB_FRZ_SHIFT &&
                   frz_bits_ff == FRZ_CNT_W'(FRZ_BITS - 1)) begin
         frz_req_ff <= {dat_sync_ff[2], frz_shift_ff[FRZ_BITS-1:1]};
      end
   end

   // ----------------------------------------------------------------
   // Ratio decode
   // ----------------------------------------------------------------

   // Table lookup per bank
   assign half_a  = HALF_A[ctrl_ff[CTRL_SEL_A_POS +: 2]];
   assign half_b  = HALF_B[ctrl_ff[CTRL_SEL_B_POS +: 2]];
   assign half_c  = HALF_C[ctrl_ff[CTRL_SEL_C_POS +: 2]];
   assign half_fb = HALF_FB[ctrl_ff[CTRL_SEL_FB_POS +: 3]];
   assign inv_c   = {{2{ctrl_ff[CTRL_INV_POS]}}, 2'b00};

   // ----------------------------------------------------------------
   // Divider banks
   // ----------------------------------------------------------------

   // First bank
   pllodb_div_bank #(.N(BANK_OUTS)) u_bank_a (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .restart    (restart_ff),
      .tick       (tick),
      .half_ratio (half_a),
      .freeze_req (frz_req_ff[FRZ_POS_A +: BANK_OUTS]),
      .invert     (4'h0),
      .q          (q_a),
      .frozen     (frozen[FRZ_POS_A +: BANK_OUTS])
   );

   // Second bank
   pllodb_div_bank #(.N(BANK_OUTS)) u_bank_b (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .restart    (restart_ff),
      .tick       (tick),
      .half_ratio (half_b),
      .freeze_req (frz_req_ff[FRZ_POS_B +: BANK_OUTS]),
      .invert     (4'h0),
      .q          (q_b),
      .frozen     (frozen[FRZ_POS_B +: BANK_OUTS])
   );

   // Third bank, upper two outputs may be inverted
   pllodb_div_bank #(.N(BANK_OUTS)) u_bank_c (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .restart    (restart_ff),
      .tick       (tick),
      .half_ratio (half_c),
      .freeze_req (frz_req_ff[FRZ_POS_C +: BANK_OUTS]),
      .invert     (inv_c),
      .q          (q_c),
      .frozen     (frozen[FRZ_POS_C +: BANK_OUTS])
   );

   // Return output, fed back to the loop by outside wiring
   pllodb_div_bank #(.N(1)) u_bank_fb (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .restart    (restart_ff),
      .tick       (tick),
      .half_ratio (half_fb),
      .freeze_req (frz_req_ff[FRZ_POS_FB]),
      .invert     (1'b0),
      .q          (q_fb),
      .frozen     (frozen[FRZ_POS_FB])
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign first_bank_outputs  = q_a;
   assign second_bank_outputs = q_b;
   assign third_bank_outputs  = q_c;
   assign loop_return_output  = q_fb;
   assign lock_ok             = lock_ff;
   assign prdata              = prdata_ff;
   assign pready              = pready_ff;
   assign pslverr             = pslverr_ff;

endmodule

// ==== rtl/pllodb_pkg.sv ====
package pllodb_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ        = 200;                          // Oscillator clock rate
   localparam int LOCK_TIME_MS   = 10;                           // Longest settle time
   localparam int LOCK_CYCLES    = LOCK_TIME_MS * CLK_MHZ * 1000; // Rounded down, exact here

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int BANK_OUTS      = 4;                            // Outputs per bank
   localparam int FRZ_BITS       = 13;                           // Three banks plus return
   localparam int HALF_W         = 4;                            // Half-ratio counter width
   localparam int FRZ_CNT_W      = 4;                            // Serial bit counter width

   // Freeze vector positions
   localparam int FRZ_POS_A      = 0;
   localparam int FRZ_POS_B      = 4;
   localparam int FRZ_POS_C      = 8;
   localparam int FRZ_POS_FB     = 12;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
   localparam logic [7:0] REG_FRZ_OFS    = 8'h04;
   localparam logic [7:0] REG_STAT_OFS   = 8'h08;
   localparam logic [7:0] REG_OUTS_OFS   = 8'h0C;

   // Control field positions
   localparam int CTRL_SEL_A_POS  = 0;   // Two bits
   localparam int CTRL_SEL_B_POS  = 2;   // Two bits
   localparam int CTRL_SEL_C_POS  = 4;   // Two bits
   localparam int CTRL_SEL_FB_POS = 6;   // Three bits, top bit halves return clock
   localparam int CTRL_HALVE_POS  = 9;   // Extra divide-by-two ahead of all banks
   localparam int CTRL_INV_POS    = 10;  // Invert third bank outputs two and three
   localparam int CTRL_W          = 11;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

   // Status field positions
   localparam int STAT_LOCK_POS   = 0;
   localparam int STAT_BUSY_POS   = 1;

   // ----------------------------------------------------------------
   // Divide tables, stored as half ratios
   // ----------------------------------------------------------------
   localparam logic [HALF_W-1:0] HALF_A  [4] = '{4'h2, 4'h3, 4'h4, 4'h6};
   localparam logic [HALF_W-1:0] HALF_B  [4] = '{4'h2, 4'h3, 4'h4, 4'h5};
   localparam logic [HALF_W-1:0] HALF_C  [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
   localparam logic [HALF_W-1:0] HALF_FB [8] = '{4'h2, 4'h3, 4'h4, 4'h5,
                                                 4'h4, 4'h6, 4'h8, 4'hA};

   // Serial freeze port states
   typedef enum logic [1:0] {
      PLLODB_FRZ_IDLE  = 2'b01,
      PLLODB_FRZ_SHIFT = 2'b10
   } pllodb_frz_state_t;

endpackage

// ==== rtl/pllodb_div_bank.sv ====
`timescale 1ns/10ps
module pllodb_div_bank
   import pllodb_pkg::*;
#(
   parameter int N = 4                                   // Outputs sharing one counter
) (
   input  wire logic              clk,                   // Oscillator clock
   input  wire logic              sys_rst,               // Synchronous reset
   input  wire logic              restart,               // Realign counter to zero
   input  wire logic              tick,                  // Advance enable from prescaler
   input  wire logic [HALF_W-1:0] half_ratio,            // Half of divide ratio
   input  wire logic [N-1:0]      freeze_req,            // Requested freeze per output
   input  wire logic [N-1:0]      invert,                // Invert per output
   output logic      [N-1:0]      q,                     // Divided clock outputs
   output logic      [N-1:0]      frozen                 // Freeze state in effect
);

   // ----------------------------------------------------------------
   // Shared counter
   // ----------------------------------------------------------------
   logic [HALF_W-1:0] cnt_ff;
   logic              raw_ff;
   logic [N-1:0]      q_ff;
   logic [N-1:0]      frz_ff;

   // Half-period counter, one for the whole bank
   always_ff @(posedge clk) begin
      if (sys_rst || restart) begin
         cnt_ff <= '0;
         raw_ff <= 1'b0;
      end else if (tick) begin
         if (cnt_ff == half_ratio - 4'h1) begin
            cnt_ff <= '0;
            raw_ff <= ~raw_ff;
         end else begin
            cnt_ff <= cnt_ff + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Per-output freeze and polarity
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_out
         logic lvl;
         assign lvl = raw_ff ^ invert[i];

         // Freeze changes only while the clock is low
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               frz_ff[i] <= 1'b0;
            end else if (!lvl) begin
               frz_ff[i] <= freeze_req[i];
            end
         end

         // Frozen output held low, counter keeps running
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               q_ff[i] <= 1'b0;
            end else begin
               q_ff[i] <= lvl & ~frz_ff[i];
            end
         end
      end
   endgenerate

   assign q      = q_ff;
   assign frozen = frz_ff;

endmodule

// ==== verification/pllodb_chk_sva.sv ====
`timescale 1ns/10ps
module pllodb_chk
   import pllodb_pkg::*;
#(
   parameter int LOCK_CNT = LOCK_CYCLES // Settle cycles
) (
   input wire logic        clk,                 // Clock
   input wire logic        sys_rst,             // Reset
   input wire logic        psel,                // APB
   input wire logic        penable,             // APB
   input wire logic        pwrite,              // APB
   input wire logic [7:0]  paddr,               // APB
   input wire logic [31:0] pwdata,              // APB
   input wire logic [31:0] prdata,              // APB
   input wire logic        pready,              // APB
   input wire logic        pslverr,             // APB
   input wire logic        frz_clk,             // Serial
   input wire logic        frz_data,            // Serial
   input wire logic [3:0]  first_bank_outputs,  // Bank 1
   input wire logic [3:0]  second_bank_outputs, // Bank 2
   input wire logic [3:0]  third_bank_outputs,  // Bank 3
   input wire logic        loop_return_output,  // Return
   input wire logic        lock_ok              // Lock
);
   logic [CTRL_W-1:0] ctrl_ff;
   logic [31:0]       since_ff;
   logic              unmapped;
   logic              ctrl_wr;
   // Address decode and control write strobe
   assign unmapped = !(paddr inside {REG_CTRL_OFS, REG_FRZ_OFS, REG_STAT_OFS, REG_OUTS_OFS});
   assign ctrl_wr = psel & penable & pready & pwrite & (paddr == REG_CTRL_OFS);
   // Copy of the control word
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_ff <= CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_ff <= pwdata[CTRL_W-1:0];
      end
   end
   // Cycles since reset or divide change
   always_ff @(posedge clk) begin
      if (sys_rst || (ctrl_wr && pwdata[9:0] != ctrl_ff[9:0])) begin
         since_ff <= '0;
      end else if (since_ff != 32'hFFFFFFFF) begin
         since_ff <= since_ff + 32'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Properties
   a_reset_quiet: assert property ($fell(sys_rst) |-> !lock_ok && !pready &&
      (first_bank_outputs | second_bank_outputs | third_bank_outputs) == 4'h0)
      else $error("outputs active after reset");
   a_ready_needs_sel: assert property (!psel |=> !pready)
      else $error("ready without select");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (psel && !penable && unmapped |=>
      pready && pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_ok_mapped: assert property (psel && !penable && !unmapped |=> pready && !pslverr)
      else $error("mapped access not answered");
   a_bank_a_shared: assert property (&first_bank_outputs[1:0] |=>
      first_bank_outputs[0] == first_bank_outputs[1])
      else $error("first bank outputs apart");
   a_bank_b_shared: assert property (&second_bank_outputs[3:2] |=>
      second_bank_outputs[2] == second_bank_outputs[3])
      else $error("second bank outputs apart");
   a_bank_c_shared: assert property (&third_bank_outputs[1:0] |=>
      third_bank_outputs[0] == third_bank_outputs[1])
      else $error("third bank outputs apart");
   a_lock_not_early: assert property ($rose(lock_ok) |->
      since_ff >= LOCK_CNT - 2 || since_ff < 3)
      else $error("lock reported early");
   a_lock_timely: assert property (since_ff == LOCK_CNT + 6 |-> lock_ok)
      else $error("lock reported late");
   // Main scenarios
   c_refused: cover property (pslverr);
   c_locked: cover property ($rose(lock_ok));
   c_inverted: cover property (third_bank_outputs[0] && !third_bank_outputs[2]);
endmodule

bind pllodb_top pllodb_chk #(.LOCK_CNT(LOCK_CNT)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .frz_clk(frz_clk), .frz_data(frz_data), .first_bank_outputs(first_bank_outputs),
   .second_bank_outputs(second_bank_outputs), .third_bank_outputs(third_bank_outputs),
   .loop_return_output(loop_return_output), .lock_ok(lock_ok)
);

// ==== verification/pllodb_frz_host.sv ====
`timescale 1ns/10ps
module pllodb_frz_host (
   input  wire logic clk,     // Clock
   input  wire logic fb_in,   // Return clock routed back
   output logic      frz_clk, // Serial clock
   output logic      frz_data // Serial data
);
   // Idle: clock still, data at its pull-up level
   initial begin
      frz_clk = 1'b0;
      frz_data = 1'b1;
   end
   // Rising edges of the returned clock
   int fb_rises = 0;
   always @(posedge fb_in) begin
      fb_rises++;
   end
   // Start bit, then 13 freeze bits lowest first
   task automatic send(input logic [12:0] mask);
      logic [13:0] bits;
      bits = {mask, 1'b1};
      for (int i = 0; i < 14; i++) begin
         @(posedge clk);
         frz_data <= bits[i];
         repeat (6) @(posedge clk);
         frz_clk <= 1'b1;
         repeat (6) @(posedge clk);
         frz_clk <= 1'b0;
      end
      @(posedge clk);
      frz_data <= 1'b1;
   endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
   import pllodb_pkg::*;
;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, frz_clk, frz_data, loop_return_output, lock_ok;
   logic [3:0]  first_bank_outputs, second_bank_outputs, third_bank_outputs;
   logic [12:0] outs;
   int          fails = 0;
   int          checks = 0;
   int          cyc = 0;
   assign outs = {loop_return_output, third_bank_outputs, second_bank_outputs,
                  first_bank_outputs};
   always #2.5 clk = ~clk;
   pllodb_top #(.LOCK_CNT(50)) u_pllodb_top (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .frz_clk(frz_clk), .frz_data(frz_data),
      .first_bank_outputs(first_bank_outputs), .second_bank_outputs(second_bank_outputs),
      .third_bank_outputs(third_bank_outputs), .loop_return_output(loop_return_output),
      .lock_ok(lock_ok));
   pllodb_frz_host u_host (.clk(clk), .fb_in(loop_return_output), .frz_clk(frz_clk),
      .frz_data(frz_data));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   // One APB transfer, held until ready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Access phase held until ready is seen at a rising edge
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp);
      check(e, eexp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      repeat (3) @(posedge clk);
   endtask
   // Cycles until the next rising edge of one output
   task automatic wait_rise(input int idx, output int n);
      logic prv;
      n = 0;
      #1;
      prv = outs[idx];
      while (n < 200 && !(outs[idx] && !prv)) begin
         prv = outs[idx];
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      rd_chk(REG_STAT_OFS, 32'h0, 1'b0);
      rd_chk(REG_CTRL_OFS, 32'h0, 1'b0);
      rd_chk(REG_FRZ_OFS, 32'h0, 1'b0);
      apb(1'b1, REG_FRZ_OFS, 32'h1FFF, r, e);
      check(e, 32'h0);
      rd_chk(REG_FRZ_OFS, 32'h0, 1'b0);
      rd_chk(8'h10, 32'h0, 1'b1);
      apb(1'b1, 8'h14, 32'h5, r, e);
      check(e, 32'h1);
   endtask
   task automatic t_ratios(input logic h);
      int ra[4] = '{4, 6, 8, 12};
      int rb[4] = '{4, 6, 8, 10};
      int rc[4] = '{2, 4, 6, 8};
      int rf[8] = '{4, 6, 8, 10, 8, 12, 16, 20};
      int n;
      int m;
      for (int i = 0; i < 8; i++) begin
         m = i % 4;
         wr(REG_CTRL_OFS, {22'h0, h, i[2:0], m[1:0], m[1:0], m[1:0]});
         wait_rise(12, n);
         wait_rise(12, n);
         check(n, rf[i] << h);
         if (i < 4) begin
            wait_rise(0, n);
            wait_rise(0, n);
            check(n, ra[m] << h);
            wait_rise(4, n);
            wait_rise(4, n);
            check(n, rb[m] << h);
            wait_rise(8, n);
            wait_rise(8, n);
            check(n, rc[m] << h);
         end
      end
   endtask
   task automatic t_invert();
      for (int s = 0; s < 2; s++) begin
         wr(REG_CTRL_OFS, s ? 32'h10 : 32'h410);
         repeat (6) @(posedge clk);
         for (int k = 0; k < 12; k++) begin
            #1;
            check(third_bank_outputs[3:2] ^ third_bank_outputs[1:0], s ? 32'h0 : 32'h3);
            @(posedge clk);
         end
      end
   endtask
   task automatic t_freeze();
      wr(REG_CTRL_OFS, 32'h0);
      u_host.send(13'h1001);
      repeat (20) @(posedge clk);
      rd_chk(REG_FRZ_OFS, 32'h1001, 1'b0);
      for (int k = 0; k < 16; k++) begin
         #1;
         check({first_bank_outputs[0], loop_return_output}, 32'h0);
         @(posedge clk);
      end
      u_host.send(13'h0);
      repeat (20) @(posedge clk);
      rd_chk(REG_FRZ_OFS, 32'h0, 1'b0);
      for (int k = 0; k < 16; k++) begin
         #1;
         check(first_bank_outputs[0] ^ first_bank_outputs[1], 32'h0);
         @(posedge clk);
      end
      u_host.send(13'h0FFF);
      sys_rst <= 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk(REG_FRZ_OFS, 32'h0, 1'b0);
   endtask
   task automatic t_lock();
      int n;
      n = 0;
      wr(REG_CTRL_OFS, 32'h3F);
      #1;
      check(lock_ok, 32'h0);
      while (lock_ok !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(n >= 40 && n <= 56, 32'h1);
      rd_chk(REG_STAT_OFS, 32'h1, 1'b0);
      // Return clock seen by the loop: ten periods of four cycles
      #1;
      n = u_host.fb_rises;
      repeat (40) @(posedge clk);
      #1;
      check(u_host.fb_rises - n, 32'hA);
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_ratios(1'b0);
      t_ratios(1'b1);
      t_invert();
      t_freeze();
      t_lock();
      stop_test();
   end
endmodule
